// ==== sfsp_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sfsp_defines.svh"

module sfsp_ctrl
	import sfsp_pkg::*;
(
	// Clock and reset.
	input wire logic i_core_clk,
	input wire logic i_reset,
	// Flash link.
	input wire logic i_cs_n,
	input wire logic i_sck,
	input wire logic [3:0] i_io,
	output logic [3:0] o_io,
	output logic [3:0] o_io_oe_n,
	// Array engine.
	input wire logic i_op_start,
	input wire logic i_op_erase,
	input wire logic i_op_done,
	output logic o_op_pause,
	output logic o_op_resume,
	output logic o_soft_reset,
	// Forwarded commands.
	output logic o_cmd_valid,
	output logic [7:0] o_cmd_code,
	// State.
	output logic [15:0] o_status,
	output logic o_quad_mode,
	output logic o_deep_pd,
	output logic o_wake_busy
);

	localparam int SUS_MAX = `SFSP_TSUS_CYC;
	localparam int RES_MAX = `SFSP_TRESUME_CYC;

	logic sck_s1, sck_s2, sck_s3;
	logic cs_s1, cs_s2, cs_s3;
	logic [3:0] io_s1, io_s2;
	logic sck_rise, sck_fall, cs_rise;
	logic [5:0] cnt_q, cnt_step;
	logic [7:0] opc_q, opc_now;
	logic strobe, exact8, frame_ok, soft_rst;
	logic quad_q, wel_q, wip_q, erase_op_q, psus_q, esus_q, rst_en_q;
	logic res_pend_q, id_act_q, pause_q, resume_q, cmd_valid_q;
	logic [7:0] cmd_code_q, id_sh_q;
	logic [3:0] io_q, oe_n_q;
	logic [15:0] sus_cnt_q, tmr_q;
	logic acc_sus, acc_res, acc_pd;
	sfsp_pwr_t pwr_q;

	function automatic logic prog_barred(input logic [7:0] op);
		prog_barred = op inside {`SFSP_OP_WRSR, `SFSP_OP_SEC_ERASE,
			`SFSP_OP_SEC_PROG, `SFSP_OP_SE, `SFSP_OP_BE32, `SFSP_OP_BE64,
			`SFSP_OP_CE_A, `SFSP_OP_CE_B, `SFSP_OP_PP, `SFSP_OP_QPP};
	endfunction

	function automatic logic erase_barred(input logic [7:0] op);
		erase_barred = op inside {`SFSP_OP_WRSR, `SFSP_OP_SEC_ERASE,
			`SFSP_OP_SE, `SFSP_OP_BE32, `SFSP_OP_BE64, `SFSP_OP_CE_A,
			`SFSP_OP_CE_B};
	endfunction

	function automatic logic op_allowed(input logic [7:0] op,
		input sfsp_pwr_t pwr, input logic ps, input logic es);
		logic ok;
		ok = 1'b0;
		unique case (pwr)
			PWR_STANDBY: ok = !(ps && prog_barred(op))
				&& !(es && erase_barred(op));
			PWR_DEEP: ok = op inside {`SFSP_OP_WAKE_ID, `SFSP_OP_RST_EN,
				`SFSP_OP_RST};
			PWR_ENTER: ok = 1'b0;
			PWR_WAKE: ok = 1'b0;
		endcase
		op_allowed = ok;
	endfunction

	// Link inputs pass two flops; the third stage only serves edge finding.
	always_ff @(posedge i_core_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			sck_s1 <= 1'b0;
			sck_s2 <= 1'b0;
			sck_s3 <= 1'b0;
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			cs_s3 <= 1'b1;
			io_s1 <= 4'h0;
			io_s2 <= 4'h0;
		end
		else
		begin
			sck_s1 <= i_sck;
			sck_s2 <= sck_s1;
			sck_s3 <= sck_s2;
			cs_s1 <= i_cs_n;
			cs_s2 <= cs_s1;
			cs_s3 <= cs_s2;
			io_s1 <= i_io;
			io_s2 <= io_s1;
		end
	end

	assign sck_rise = sck_s2 && !sck_s3 && !cs_s2;
	assign sck_fall = !sck_s2 && sck_s3 && !cs_s2;
	assign cs_rise = cs_s2 && !cs_s3;
	assign cnt_step = quad_q ? `SFSP_STEP_QPI : `SFSP_STEP_SPI;
	assign opc_now = quad_q ? {opc_q[3:0], io_s2} : {opc_q[6:0], io_s2[0]};
	assign strobe = sck_rise && (cnt_q < `SFSP_OPC_BITS)
		&& (cnt_q + cnt_step == `SFSP_OPC_BITS);
	assign exact8 = (cnt_q == `SFSP_OPC_BITS);
	assign frame_ok = cs_rise && exact8 && op_allowed(opc_q, pwr_q, psus_q,
		esus_q);
	assign soft_rst = frame_ok && (opc_q == `SFSP_OP_RST) && rst_en_q;
	assign acc_sus = frame_ok && (opc_q == `SFSP_OP_SUSPEND) && !psus_q
		&& !esus_q && wip_q && !soft_rst;
	assign acc_res = frame_ok && (opc_q == `SFSP_OP_RESUME)
		&& (psus_q || esus_q) && !wip_q;
	assign acc_pd = frame_ok && (opc_q == `SFSP_OP_PWR_DOWN) && !wip_q
		&& (pwr_q == PWR_STANDBY);

	// Opcode shifter and bit count of the current frame.
	always_ff @(posedge i_core_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			cnt_q <= 6'h00;
			opc_q <= 8'h00;
		end
		else if (cs_s2)
			cnt_q <= 6'h00;
		else if (sck_rise)
		begin
			if (cnt_q < `SFSP_OPC_BITS)
				opc_q <= opc_now;
			if (cnt_q < `SFSP_CNT_SAT)
				cnt_q <= cnt_q + cnt_step;
		end
	end

	// Opcodes that the rest of the device acts on are forwarded here.
	always_ff @(posedge i_core_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			cmd_valid_q <= 1'b0;
			cmd_code_q <= 8'h00;
		end
		else
		begin
			cmd_valid_q <= strobe && op_allowed(opc_now, pwr_q, psus_q,
				esus_q);
			if (strobe)
				cmd_code_q <= opc_now;
		end
	end

	// Command mode, write enable latch and the software reset arming.
	always_ff @(posedge i_core_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			quad_q <= 1'b0;
			wel_q <= 1'b0;
			rst_en_q <= 1'b0;
		end
		else if (soft_rst)
		begin
			quad_q <= 1'b0;
			wel_q <= 1'b0;
			rst_en_q <= 1'b0;
		end
		else
		begin
			if (frame_ok && opc_q == `SFSP_OP_QPI_ON)
				quad_q <= 1'b1;
			else if (frame_ok && opc_q == `SFSP_OP_QPI_OFF)
				quad_q <= 1'b0;
			if (frame_ok && opc_q == `SFSP_OP_WREN)
				wel_q <= 1'b1;
			else if ((frame_ok && opc_q == `SFSP_OP_WRDI) || i_op_done)
				wel_q <= 1'b0;
			if (cs_rise)
				rst_en_q <= frame_ok && (opc_q == `SFSP_OP_RST_EN);
		end
	end

	// Busy flag and the kind of cycle that is running.
	always_ff @(posedge i_core_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			wip_q <= 1'b0;
			erase_op_q <= 1'b0;
			res_pend_q <= 1'b0;
		end
		else if (soft_rst)
		begin
			wip_q <= 1'b0;
			res_pend_q <= 1'b0;
		end
		else
		begin
			res_pend_q <= acc_res;
			if (i_op_start)
				erase_op_q <= i_op_erase;
			if (i_op_start || res_pend_q)
				wip_q <= 1'b1;
			else if (i_op_done || sus_cnt_q == 16'h0001)
				wip_q <= 1'b0;
		end
	end

	// Suspend flags, latency counter and the pulses to the array engine.
	always_ff @(posedge i_core_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			psus_q <= 1'b0;
			esus_q <= 1'b0;
			sus_cnt_q <= 16'h0000;
			pause_q <= 1'b0;
			resume_q <= 1'b0;
		end
		else if (soft_rst)
		begin
			psus_q <= 1'b0;
			esus_q <= 1'b0;
			sus_cnt_q <= 16'h0000;
			pause_q <= 1'b0;
			resume_q <= 1'b0;
		end
		else
		begin
			pause_q <= acc_sus;
			resume_q <= acc_res;
			if (acc_sus)
			begin
				psus_q <= !erase_op_q;
				esus_q <= erase_op_q;
				sus_cnt_q <= 16'(`SFSP_TSUS_CYC);
			end
			else if (sus_cnt_q != 16'h0000)
				sus_cnt_q <= sus_cnt_q - 16'h0001;
			if (acc_res)
			begin
				psus_q <= 1'b0;
				esus_q <= 1'b0;
			end
		end
	end

	// Power state: entry delay, deep power-down and the wake delay.
	always_ff @(posedge i_core_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			pwr_q <= PWR_STANDBY;
			tmr_q <= 16'h0000;
		end
		else if (soft_rst)
		begin
			pwr_q <= PWR_STANDBY;
			tmr_q <= 16'h0000;
		end
		else
		begin
			unique case (pwr_q)
				PWR_STANDBY:
					if (acc_pd)
					begin
						pwr_q <= PWR_ENTER;
						tmr_q <= 16'(`SFSP_TDP_CYC);
					end
				PWR_ENTER:
					if (tmr_q == 16'h0001)
						pwr_q <= PWR_DEEP;
					else
						tmr_q <= tmr_q - 16'h0001;
				PWR_DEEP:
					if (cs_rise && cnt_q >= `SFSP_OPC_BITS
						&& opc_q == `SFSP_OP_WAKE_ID)
					begin
						pwr_q <= PWR_WAKE;
						tmr_q <= exact8 ? 16'(`SFSP_WAKE_DELAY_CYC)
							: 16'(`SFSP_WAKE_WITH_ID_DELAY_CYC);
					end
				PWR_WAKE:
					if (tmr_q == 16'h0001)
						pwr_q <= PWR_STANDBY;
					else
						tmr_q <= tmr_q - 16'h0001;
			endcase
		end
	end

	// Device ID stream after the opcode and three dummy bytes.
	always_ff @(posedge i_core_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			id_act_q <= 1'b0;
			id_sh_q <= `SFSP_DEV_ID;
			io_q <= `SFSP_IO_IDLE;
			oe_n_q <= `SFSP_IO_IDLE;
		end
		else if (cs_s2)
		begin
			id_act_q <= 1'b0;
			id_sh_q <= `SFSP_DEV_ID;
			oe_n_q <= `SFSP_IO_IDLE;
		end
		else if (sck_fall && opc_q == `SFSP_OP_WAKE_ID
			&& cnt_q >= `SFSP_ID_BITS && !wip_q
			&& (pwr_q == PWR_STANDBY || pwr_q == PWR_DEEP))
		begin
			id_act_q <= 1'b1;
			if (quad_q)
			begin
				io_q <= id_sh_q[7:4];
				id_sh_q <= {id_sh_q[3:0], id_sh_q[7:4]};
				oe_n_q <= `SFSP_OE_QPI_OUT;
			end
			else
			begin
				io_q <= {2'h3, id_sh_q[7], 1'h1};
				id_sh_q <= {id_sh_q[6:0], id_sh_q[7]};
				oe_n_q <= `SFSP_OE_SPI_OUT;
			end
		end
	end

	assign o_io = io_q;
	assign o_io_oe_n = oe_n_q;
	assign o_op_pause = pause_q;
	assign o_op_resume = resume_q;
	assign o_soft_reset = soft_rst;
	assign o_cmd_valid = cmd_valid_q;
	assign o_cmd_code = cmd_code_q;
	assign o_quad_mode = quad_q;
	assign o_deep_pd = (pwr_q == PWR_DEEP);
	assign o_wake_busy = (pwr_q == PWR_WAKE);

	always_comb
	begin
		o_status = `SFSP_STATUS_RST;
		o_status[`SFSP_BIT_WIP] = wip_q;
		o_status[`SFSP_BIT_WEL] = wel_q;
		o_status[`SFSP_BIT_QE] = `SFSP_QE_RST;
		o_status[`SFSP_BIT_SUS_P] = psus_q;
		o_status[`SFSP_BIT_SUS_E] = esus_q;
	end

	AST_SUS_IGNORED: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(cs_rise && exact8 && opc_q == `SFSP_OP_SUSPEND && !soft_rst
		&& (psus_q || esus_q || !wip_q)) |=> $stable({psus_q, esus_q}))
		else $error("Suspend taken against its conditions.");

	AST_SUS_LATENCY: assert property (@(posedge i_core_clk) disable iff (i_reset)
		acc_sus |=> (psus_q || esus_q) ##[0:SUS_MAX] !wip_q)
		else $error("Suspend did not settle in time.");

	AST_RES_IGNORED: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(frame_ok && opc_q == `SFSP_OP_RESUME && !psus_q && !esus_q)
		|=> !o_op_resume)
		else $error("Resume without an active suspend.");

	AST_RES_WIP: assert property (@(posedge i_core_clk) disable iff (i_reset)
		acc_res |=> !psus_q && !esus_q ##[0:RES_MAX] wip_q)
		else $error("Resume did not restart the cycle in time.");

	AST_DPD_ONLY: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(o_cmd_valid && $past(pwr_q) == PWR_DEEP) |-> o_cmd_code inside
		{`SFSP_OP_WAKE_ID, `SFSP_OP_RST_EN, `SFSP_OP_RST})
		else $error("Command passed in deep power-down.");

	AST_DPD_DELAY: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(pwr_q == PWR_ENTER && tmr_q > 16'h0001) |=> pwr_q != PWR_DEEP)
		else $error("Deep power-down entered early.");

	AST_DPD_BUSY: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(cs_rise && opc_q == `SFSP_OP_PWR_DOWN && wip_q && !soft_rst
		&& !i_op_done && pwr_q == PWR_STANDBY)
		|=> pwr_q == PWR_STANDBY && wip_q)
		else $error("Power-down disturbed a busy cycle.");

	AST_WAKE_BUSY: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(pwr_q == PWR_WAKE) |=> !o_cmd_valid)
		else $error("Command accepted during wake delay.");

	AST_ID_WIP: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(wip_q && !id_act_q) |=> !id_act_q)
		else $error("Device ID driven while busy.");

	AST_MODE_KEEP: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(frame_ok && !i_op_done && (opc_q == `SFSP_OP_QPI_ON
		|| opc_q == `SFSP_OP_QPI_OFF)) |=> $stable({wel_q, psus_q, esus_q}))
		else $error("Mode switch lost latch or suspend state.");

	AST_PROG_BAR: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(strobe && psus_q && prog_barred(opc_now)) |=> !o_cmd_valid)
		else $error("Barred opcode passed in program suspend.");

endmodule
`default_nettype wire

// ==== sfsp_defines.svh ====
`ifndef SFSP_DEFINES_SVH
`define SFSP_DEFINES_SVH

`define SFSP_OP_SUSPEND 8'h75
`define SFSP_OP_RESUME 8'h7A
`define SFSP_OP_PWR_DOWN 8'hB9
`define SFSP_OP_WAKE_ID 8'hAB
`define SFSP_OP_QPI_ON 8'h38
`define SFSP_OP_QPI_OFF 8'hFF
`define SFSP_OP_RST_EN 8'h66
`define SFSP_OP_RST 8'h99
`define SFSP_OP_WREN 8'h06
`define SFSP_OP_WRDI 8'h04
`define SFSP_OP_WRSR 8'h01
`define SFSP_OP_SEC_ERASE 8'h44
`define SFSP_OP_SEC_PROG 8'h42
`define SFSP_OP_SE 8'h20
`define SFSP_OP_BE32 8'h52
`define SFSP_OP_BE64 8'hD8
`define SFSP_OP_CE_A 8'hC7
`define SFSP_OP_CE_B 8'h60
`define SFSP_OP_PP 8'h02
`define SFSP_OP_QPP 8'h32
`define SFSP_OP_PARAM 8'h5A

`define SFSP_BIT_WIP 0
`define SFSP_BIT_WEL 1
`define SFSP_BIT_QE 9
`define SFSP_BIT_SUS_P 10
`define SFSP_BIT_SUS_E 15
`define SFSP_STATUS_RST 16'h0000
`define SFSP_QE_RST 1'h1
`define SFSP_IO_IDLE 4'hF
`define SFSP_OE_SPI_OUT 4'hD
`define SFSP_OE_QPI_OUT 4'h0
`define SFSP_DEV_ID 8'h17

`define SFSP_OPC_BITS 6'h08
`define SFSP_ID_BITS 6'h20
`define SFSP_CNT_SAT 6'h28
`define SFSP_STEP_SPI 6'h01
`define SFSP_STEP_QPI 6'h04

`define SFSP_CLK_MHZ 50
`define SFSP_TDP_NS 3000
`define SFSP_WAKE_DELAY_NS 8000
`define SFSP_WAKE_WITH_ID_DELAY_NS 8000
`define SFSP_TSUS_NS 20000
`define SFSP_TRESUME_NS 200
`define SFSP_TDP_CYC ((`SFSP_TDP_NS * `SFSP_CLK_MHZ + 999) / 1000)
`define SFSP_WAKE_DELAY_CYC ((`SFSP_WAKE_DELAY_NS * `SFSP_CLK_MHZ + 999) / 1000)
`define SFSP_WAKE_WITH_ID_DELAY_CYC ((`SFSP_WAKE_WITH_ID_DELAY_NS * `SFSP_CLK_MHZ + 999) / 1000)
`define SFSP_TSUS_CYC ((`SFSP_TSUS_NS * `SFSP_CLK_MHZ) / 1000)
`define SFSP_TRESUME_CYC ((`SFSP_TRESUME_NS * `SFSP_CLK_MHZ) / 1000)

`endif

// ==== sfsp_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sfsp_defines.svh"

module sfsp_host (
	// Core clock used to pace the serial clock.
	input wire logic i_core_clk,
	// Device data outputs.
	input wire logic [3:0] i_dev_io,
	// Link towards the device.
	output logic o_cs_n,
	output logic o_sck,
	output logic [3:0] o_io
);
	logic [31:0] id_shift;
	bit quad;

	initial
	begin
		o_cs_n = 1'b1;
		o_sck = 1'b0;
		o_io = 4'hF;
		id_shift = 32'h0;
		quad = 1'b0;
	end

	// Half of the 160 ns serial clock period.
	task automatic half();
		repeat (4) @(negedge i_core_clk);
	endtask

	// Device data is sampled late in the high phase, where it has settled.
	task automatic tick(input logic [3:0] v);
		o_io = v;
		half();
		o_sck = 1'b1;
		half();
		if (quad)
			id_shift = {id_shift[27:0], i_dev_io};
		else
			id_shift = {id_shift[30:0], i_dev_io[1]};
		o_sck = 1'b0;
	endtask

	// Extra clocks after the opcode carry all-ones dummy data.
	task automatic frame(input logic [7:0] op, input int extra);
		int i;
		@(negedge i_core_clk);
		o_cs_n = 1'b0;
		half();
		if (quad)
		begin
			tick(op[7:4]);
			tick(op[3:0]);
		end
		else
			for (i = 7; i >= 0; i--)
				tick({3'h7, op[i]});
		for (i = 0; i < extra; i++)
			tick(4'hF);
		half();
		o_cs_n = 1'b1;
		o_io = ~o_io;
		if (extra == 0 && op == `SFSP_OP_QPI_ON)
			quad = 1'b1;
		if (extra == 0 && (op == `SFSP_OP_QPI_OFF || op == `SFSP_OP_RST))
			quad = 1'b0;
		repeat (12) @(negedge i_core_clk);
	endtask
endmodule

`default_nettype wire

// ==== sfsp_pkg.sv ====
`default_nettype none
package sfsp_pkg;
	typedef enum logic [1:0] {
		PWR_STANDBY,
		PWR_ENTER,
		PWR_DEEP,
		PWR_WAKE
	} sfsp_pwr_t;
endpackage
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sfsp_defines.svh"

module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0;
	logic erase = 1'b0;
	logic done = 1'b0;
	logic cs_n, sck, pause, resume, srst, cval, quad, deep, wake;
	logic [3:0] io_h, io_d, oe_n;
	logic [7:0] ccode;
	logic [15:0] status;
	int error_cnt = 0;
	int checks_done = 0;
	int cyc = 0;
	int n_pause = 0;
	int n_res = 0;
	int n_cmd = 0;
	int n_srst = 0;
	localparam logic [15:0] ID2 = {`SFSP_DEV_ID, `SFSP_DEV_ID};

	sfsp_ctrl uut (.i_core_clk(clk), .i_reset(rst), .i_cs_n(cs_n),
		.i_sck(sck), .i_io(io_h), .o_io(io_d), .o_io_oe_n(oe_n),
		.i_op_start(start), .i_op_erase(erase), .i_op_done(done),
		.o_op_pause(pause), .o_op_resume(resume), .o_soft_reset(srst),
		.o_cmd_valid(cval), .o_cmd_code(ccode), .o_status(status),
		.o_quad_mode(quad), .o_deep_pd(deep), .o_wake_busy(wake));

	sfsp_host host (.i_core_clk(clk), .i_dev_io(io_d), .o_cs_n(cs_n),
		.o_sck(sck), .o_io(io_h));

	always #10 clk = ~clk;

	always @(posedge clk)
	begin
		cyc++;
		if (pause === 1'b1) n_pause++;
		if (resume === 1'b1) n_res++;
		if (cval === 1'b1) n_cmd++;
		if (srst === 1'b1) n_srst++;
		if (cyc == 60000)
		begin
			error_cnt++;
			close_out();
		end
	end

	task automatic close_out();
		if (error_cnt == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_n(input int got, input int exp);
		checks_done++;
		if (got != exp)
		begin
			error_cnt++;
			$display("ERROR %0t count %0d expected %0d", $time, got, exp);
		end
	endtask

	task automatic engine(input logic er, input logic fin);
		@(negedge clk);
		erase = er;
		start = !fin;
		done = fin;
		@(negedge clk);
		start = 1'b0;
		done = 1'b0;
		@(negedge clk);
	endtask

	task automatic wait_wip(input logic v);
		int k;
		k = 0;
		while (status[0] !== v && k < 1100)
		begin
			@(negedge clk);
			k++;
		end
		chk_v(status[0], v);
	endtask

	task automatic t_suspend(input logic er);
		logic [7:0] bad [10] = '{8'h01, 8'h44, 8'h20, 8'h52, 8'hD8, 8'hC7,
			8'h60, 8'h42, 8'h02, 8'h32};
		int c, p, i;
		engine(er, 1'b0);
		chk_v(status, er ? 16'h0201 : 16'h0201);
		p = n_pause;
		host.frame(`SFSP_OP_SUSPEND, 0);
		chk_n(n_pause, p + 1);
		chk_v(status & 16'h8401, er ? 16'h8001 : 16'h0401);
		host.frame(`SFSP_OP_SUSPEND, 0);
		chk_n(n_pause, p + 1);
		c = n_cmd;
		for (i = 0; i < (er ? 7 : 10); i++)
			host.frame(bad[i], 0);
		chk_n(n_cmd, c);
		if (er)
		begin
			host.frame(`SFSP_OP_PP, 0);
			chk_n(n_cmd, c + 1);
			chk_v(ccode, `SFSP_OP_PP);
		end
		wait_wip(1'b0);
		p = n_res;
		host.frame(`SFSP_OP_RESUME, 0);
		chk_n(n_res, p + 1);
		chk_v(status, 16'h0201);
		engine(er, 1'b1);
		chk_v(status, 16'h0200);
	endtask

	task automatic t_idle();
		int p, r;
		p = n_pause;
		r = n_res;
		host.frame(`SFSP_OP_SUSPEND, 0);
		host.frame(`SFSP_OP_RESUME, 0);
		chk_n(n_pause, p);
		chk_n(n_res, r);
		chk_v(status, 16'h0200);
	endtask

	task automatic t_power();
		int c;
		engine(1'b1, 1'b0);
		host.frame(`SFSP_OP_PWR_DOWN, 0);
		repeat (200) @(negedge clk);
		chk_v({deep, status[14:0]}, 16'h0201);
		engine(1'b1, 1'b1);
		host.frame(`SFSP_OP_PWR_DOWN, 1);
		repeat (200) @(negedge clk);
		chk_v(deep, 1'b0);
		host.frame(`SFSP_OP_PWR_DOWN, 0);
		repeat (100) @(negedge clk);
		chk_v(deep, 1'b0);
		repeat (100) @(negedge clk);
		chk_v(deep, 1'b1);
		c = n_cmd;
		host.frame(`SFSP_OP_WREN, 0);
		chk_n(n_cmd, c);
		chk_v(status, 16'h0200);
		host.frame(`SFSP_OP_WAKE_ID, 0);
		chk_v({deep, wake}, 2'b01);
		c = n_cmd;
		host.frame(`SFSP_OP_WREN, 0);
		chk_n(n_cmd, c);
		repeat (400) @(negedge clk);
		chk_v(wake, 1'b0);
		host.frame(`SFSP_OP_WREN, 0);
		chk_v(status, 16'h0202);
		host.frame(`SFSP_OP_PWR_DOWN, 0);
		repeat (200) @(negedge clk);
		chk_v(deep, 1'b1);
		host.frame(`SFSP_OP_WAKE_ID, 40);
		chk_v(host.id_shift[15:0], ID2);
		chk_v({deep, wake}, 2'b01);
		repeat (400) @(negedge clk);
		chk_v(wake, 1'b0);
	endtask

	task automatic t_id(input int extra, input int when, input logic [3:0] oe);
		fork
			host.frame(`SFSP_OP_WAKE_ID, extra);
			begin
				repeat (when) @(negedge clk);
				chk_v(oe_n, oe);
			end
		join
	endtask

	task automatic t_modes();
		int c;
		t_id(40, 300, `SFSP_OE_SPI_OUT);
		chk_v(host.id_shift[15:0], ID2);
		engine(1'b0, 1'b0);
		t_id(40, 300, `SFSP_IO_IDLE);
		engine(1'b0, 1'b1);
		host.frame(`SFSP_OP_QPI_ON, 0);
		chk_v({quad, status[14:0]}, 16'h8200);
		t_id(10, 90, `SFSP_OE_QPI_OUT);
		chk_v(host.id_shift[15:0], ID2);
		c = n_cmd;
		host.frame(`SFSP_OP_PARAM, 0);
		chk_n(n_cmd, c + 1);
		chk_v(ccode, `SFSP_OP_PARAM);
		host.frame(`SFSP_OP_QPI_OFF, 0);
		chk_v({quad, status[14:0]}, 16'h0200);
		c = n_cmd;
		host.frame(`SFSP_OP_PARAM, 0);
		chk_n(n_cmd, c + 1);
	endtask

	task automatic t_soft();
		int s;
		s = n_srst;
		host.frame(`SFSP_OP_WREN, 0);
		host.frame(`SFSP_OP_RST, 0);
		chk_n(n_srst, s);
		host.frame(`SFSP_OP_QPI_ON, 0);
		host.frame(`SFSP_OP_PWR_DOWN, 0);
		repeat (200) @(negedge clk);
		host.frame(`SFSP_OP_RST_EN, 0);
		host.frame(`SFSP_OP_RST, 0);
		chk_n(n_srst, s + 1);
		chk_v({deep, quad, status[13:0]}, 16'h0200);
	endtask

	initial
	begin
		repeat (3) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		chk_v({deep, quad, wake, 9'h0, oe_n}, 16'h000F);
		chk_v(status, 16'h0200);
		t_suspend(1'b0);
		t_suspend(1'b1);
		t_idle();
		t_power();
		t_modes();
		t_soft();
		close_out();
	end
endmodule

`default_nettype wire
